// >>> hw/epsd_regs.vh
// Constants for the energy pulse stepper drive block.
// Assumes a 250 MHz core clock; included by bare name.
`ifndef EPSD_REGS_VH
`define EPSD_REGS_VH

// ----------------------------------------------------------------
// Clock and pulse lengths
// ----------------------------------------------------------------
`define EPSD_CLK_MHZ        250
`define EPSD_PULSE_SHORT_US 31250
`define EPSD_PULSE_LONG_US  156250
`define EPSD_PULSE_SHORT_CYC (`EPSD_PULSE_SHORT_US * `EPSD_CLK_MHZ)
`define EPSD_PULSE_LONG_CYC  (`EPSD_PULSE_LONG_US * `EPSD_CLK_MHZ)

// ----------------------------------------------------------------
// Divisors
// ----------------------------------------------------------------
`define EPSD_DIV_K0   9'h040
`define EPSD_DIV_K1   9'h080
`define EPSD_DIV_K2   9'h020
`define EPSD_DIV_K3   9'h100
`define EPSD_DIV_TYPE 12'h00a

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EPSD_RST_TOTAL_SIGN 1'h1
`define EPSD_RST_PHASE_SIGN 3'h7

// ----------------------------------------------------------------
// Negative accumulation modes
// ----------------------------------------------------------------
`define EPSD_ACC_SIGNED3 2'h0
`define EPSD_ACC_ABS     2'h1
`define EPSD_ACC_PHASE   2'h2
`define EPSD_ACC_SIGNED  2'h3

`endif

// >>> hw/epsd_energy_pulse_stepper_drive.v
// Stepper motor and LED pulse output stage of a poly-phase meter.
// Assumes the per-phase active powers and energy pulse strobes come
// from the integrator, synchronous to core_clk_in.
//
// What this block does
// - Standalone mode when upper operating mode bit is set; drive motor.
// - Motor path is divider, then pulse limiter, then alternating decoder.
// - Motor divisor 64,128,32,256 per rate code; times ten if type bit set.
// - Motor pulse width 31.25 ms, or 156.25 ms when type bit set.
// - Successive divided pulses alternate between first and second drive.
// - No-load flag suspends integration and holds both motor pins low.
// - LED: full rate in mode 2, rate-code divisor in mode 3.
// - Accumulation mode affects only active and fundamental active power.
// - Total direction flag from summed power, phase flags from own power.
// - Mode 0: signed sum; negative clears flag and stops motor.
// - Mode 1: absolute sum, flag always one, motor runs.
// - Mode 2: per-phase Ferraris, absolute sum, flag always one, motor runs.
// - Mode 3: signed sum, motor pulses for either sign.
// - All divisors apply to the calibrated base LED pulse constant.
`timescale 1ns/1ns
`include "epsd_regs.vh"

module epsd_energy_pulse_stepper_drive #(
  parameter PW        = 24,
  parameter SHORT_CYC = `EPSD_PULSE_SHORT_CYC,
  parameter LONG_CYC  = `EPSD_PULSE_LONG_CYC
) (
  input  wire          core_clk_in,
  input  wire          resetn_in,
  input  wire [1:0]    operating_mode_select_in,
  input  wire          energy_type_select_in,
  input  wire [1:0]    motor_rate_select_in,
  input  wire [1:0]    negative_accumulation_mode_in,
  input  wire          no_load_flag_in,
  input  wire [PW-1:0] phase_r_power_in,
  input  wire [PW-1:0] phase_s_power_in,
  input  wire [PW-1:0] phase_t_power_in,
  input  wire          energy_pulse_in,
  output wire          integrate_enable_out,
  output reg           total_sign_out,
  output reg  [2:0]    phase_sign_out,
  output reg           motor_drive_first_out,
  output reg           motor_drive_second_out,
  output reg           led_pulse_out
);

  // ----------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------
  localparam        SW       = PW + 2;
  localparam [11:0] TYPE_MUL = `EPSD_DIV_TYPE;
  localparam [11:0] ONE_12   = 12'h001;
  localparam [31:0] ONE_32   = 32'h00000001;
  localparam [31:0] ZERO_32  = 32'h00000000;

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  wire standalone;
  wire led_divided;
  wire drive_kill;
  wire pulse_ok;

  assign standalone  = operating_mode_select_in[1];
  assign led_divided = operating_mode_select_in[0];
  // Motor stage stops outside standalone or in no-load
  assign drive_kill  = ~standalone | no_load_flag_in;
  // Energy pulses are dropped while integration is suspended
  assign pulse_ok    = energy_pulse_in & ~no_load_flag_in;

  // Power sum itself only steers active energy; reactive untouched
  assign integrate_enable_out = ~no_load_flag_in;

  // ----------------------------------------------------------------
  // Per-phase sign and magnitude
  // ----------------------------------------------------------------
  wire [3*PW-1:0] phase_bus;
  wire [3*SW-1:0] ext_bus;
  wire [3*SW-1:0] mag_bus;
  wire [2:0]      phase_neg;

  assign phase_bus = {phase_t_power_in,
                      phase_s_power_in,
                      phase_r_power_in};

  // Phase 0 is R, 1 is S, 2 is T
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_phase
      wire [PW-1:0] pwr;
      wire [PW-1:0] pwr_neg;
      wire [PW-1:0] pwr_mag;
      assign pwr          = phase_bus[g*PW +: PW];
      assign pwr_neg      = ~pwr + {{(PW-1){1'b0}}, 1'b1};
      assign pwr_mag      = pwr[PW-1] ? pwr_neg : pwr;
      assign phase_neg[g] = pwr[PW-1];
      // Two guard bits keep the sum of three terms exact
      assign ext_bus[g*SW +: SW] = {{2{pwr[PW-1]}}, pwr};
      assign mag_bus[g*SW +: SW] = {2'h0, pwr_mag};
    end
  endgenerate

  // ----------------------------------------------------------------
  // Accumulation policy
  // ----------------------------------------------------------------
  wire [SW-1:0] sum_signed;
  wire [SW-1:0] sum_abs;
  reg  [SW-1:0] sum_sel;
  reg           neg_block;
  wire          sum_neg;
  wire          motor_allow;

  assign sum_signed = ext_bus[0 +: SW]
                    + ext_bus[SW +: SW]
                    + ext_bus[2*SW +: SW];
  // Magnitude sum can never set the top bit
  assign sum_abs    = mag_bus[0 +: SW]
                    + mag_bus[SW +: SW]
                    + mag_bus[2*SW +: SW];

  always @* begin
    sum_sel   = sum_signed;
    neg_block = 1'b0;
    case (negative_accumulation_mode_in)
      `EPSD_ACC_SIGNED3: begin
        sum_sel   = sum_signed;
        neg_block = 1'b1;
      end
      `EPSD_ACC_ABS: begin
        sum_sel   = sum_abs;
      end
      `EPSD_ACC_PHASE: begin
        // Per-phase Ferraris: each phase counted forward only
        sum_sel   = sum_abs;
      end
      `EPSD_ACC_SIGNED: begin
        sum_sel   = sum_signed;
      end
      default: begin
        sum_sel   = sum_signed;
      end
    endcase
  end

  assign sum_neg     = sum_sel[SW-1];
  // Only the three-phase Ferraris mode stops on a negative sum
  assign motor_allow = ~(neg_block & sum_neg);

  // ----------------------------------------------------------------
  // Direction flags
  // ----------------------------------------------------------------
  // Flags lag the phase powers by one clock
  always @(posedge core_clk_in) begin
    if (!resetn_in) begin
      total_sign_out <= `EPSD_RST_TOTAL_SIGN;
      phase_sign_out <= `EPSD_RST_PHASE_SIGN;
    end else begin
      total_sign_out <= ~sum_neg;
      phase_sign_out <= ~phase_neg;
    end
  end

  // ----------------------------------------------------------------
  // Divisor selection
  // ----------------------------------------------------------------
  reg  [8:0]  base_div;
  wire [11:0] base_div_w;
  wire [23:0] type_prod;
  reg  [11:0] motor_div;

  always @* begin
    case (motor_rate_select_in)
      2'h0: base_div = `EPSD_DIV_K0;
      2'h1: base_div = `EPSD_DIV_K1;
      2'h2: base_div = `EPSD_DIV_K2;
      2'h3: base_div = `EPSD_DIV_K3;
      default: base_div = `EPSD_DIV_K0;
    endcase
  end

  assign base_div_w = {3'h0, base_div};
  // Full product width; the largest divisor still fits in 12 bits
  assign type_prod  = base_div_w * TYPE_MUL;

  // Divisor relative to base constant C
  always @* begin
    if (energy_type_select_in) begin
      motor_div = type_prod[11:0];
    end else begin
      motor_div = base_div_w;
    end
  end

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  reg  [11:0] div_cnt_q;
  wire        div_last;
  wire        div_step;
  wire        div_hit;

  assign div_last = (div_cnt_q == motor_div - ONE_12);
  // Negative sum in mode 0 freezes the motor count
  assign div_step = pulse_ok & motor_allow;
  assign div_hit  = div_step & div_last;

  always @(posedge core_clk_in) begin
    if (!resetn_in) begin
      div_cnt_q <= 12'h000;
    end else if (!standalone) begin
      div_cnt_q <= 12'h000;
    end else if (div_step) begin
      if (div_hit) begin
        div_cnt_q <= 12'h000;
      end else begin
        div_cnt_q <= div_cnt_q + ONE_12;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mono-flop
  // ----------------------------------------------------------------
  reg  [31:0] mono_cnt_q;
  wire [31:0] pulse_len;
  wire        mono_idle;
  wire        mono_last;
  wire        fire;

  assign pulse_len = energy_type_select_in ? LONG_CYC : SHORT_CYC;
  assign mono_idle = (mono_cnt_q == ZERO_32);
  assign mono_last = (mono_cnt_q == ONE_32);
  // Hits while a pulse is still running are dropped
  assign fire      = mono_idle & div_hit;

  always @(posedge core_clk_in) begin
    if (!resetn_in) begin
      mono_cnt_q <= ZERO_32;
    end else if (drive_kill) begin
      mono_cnt_q <= ZERO_32;
    end else if (!mono_idle) begin
      mono_cnt_q <= mono_cnt_q - ONE_32;
    end else if (div_hit) begin
      mono_cnt_q <= pulse_len;
    end
  end

  // ----------------------------------------------------------------
  // Alternating decoder
  // ----------------------------------------------------------------
  reg sel_q;

  // Toggle survives a cut pulse so the coils keep alternating
  always @(posedge core_clk_in) begin
    if (!resetn_in) begin
      sel_q                  <= 1'b0;
      motor_drive_first_out  <= 1'b0;
      motor_drive_second_out <= 1'b0;
    end else if (drive_kill) begin
      motor_drive_first_out  <= 1'b0;
      motor_drive_second_out <= 1'b0;
    end else if (mono_last) begin
      motor_drive_first_out  <= 1'b0;
      motor_drive_second_out <= 1'b0;
    end else if (fire) begin
      sel_q                  <= ~sel_q;
      motor_drive_first_out  <= ~sel_q;
      motor_drive_second_out <= sel_q;
    end
  end

  // ----------------------------------------------------------------
  // LED pulse output
  // ----------------------------------------------------------------
  reg  [11:0] led_cnt_q;
  wire [11:0] led_div;
  wire        led_last;
  wire        led_hit;

  // LED divider ignores the energy type select
  assign led_div  = base_div_w;
  assign led_last = (led_cnt_q == led_div - ONE_12);
  assign led_hit  = pulse_ok & led_last;

  always @(posedge core_clk_in) begin
    if (!resetn_in) begin
      led_cnt_q     <= 12'h000;
      led_pulse_out <= 1'b0;
    end else if (!standalone) begin
      led_cnt_q     <= 12'h000;
      led_pulse_out <= 1'b0;
    end else if (!led_divided) begin
      led_cnt_q     <= 12'h000;
      led_pulse_out <= pulse_ok;
    end else begin
      if (pulse_ok) begin
        if (led_hit) begin
          led_cnt_q <= 12'h000;
        end else begin
          led_cnt_q <= led_cnt_q + ONE_12;
        end
      end
      led_pulse_out <= led_hit;
    end
  end

endmodule // epsd_energy_pulse_stepper_drive

// >>> tb/epsd_drive_sva.sv
// Concurrent checks on the stepper drive block ports.
// Assumes one clock and a synchronous active low reset.
`timescale 1ns/1ns
module epsd_drive_sva #(
  parameter PW        = 24,
  parameter SHORT_CYC = 10,
  parameter LONG_CYC  = 50
) (
  input wire          core_clk_in,
  input wire          resetn_in,
  input wire [1:0]    operating_mode_select_in,
  input wire          energy_type_select_in,
  input wire [1:0]    negative_accumulation_mode_in,
  input wire          no_load_flag_in,
  input wire [PW-1:0] phase_r_power_in,
  input wire [PW-1:0] phase_s_power_in,
  input wire [PW-1:0] phase_t_power_in,
  input wire          integrate_enable_out,
  input wire          total_sign_out,
  input wire [2:0]    phase_sign_out,
  input wire          motor_drive_first_out,
  input wire          motor_drive_second_out,
  input wire          led_pulse_out
);
  wire                 m1  = motor_drive_first_out;
  wire                 m2  = motor_drive_second_out;
  wire                 nl  = no_load_flag_in;
  wire [1:0]           acc = negative_accumulation_mode_in;
  wire signed [PW+1:0] sum = $signed(phase_r_power_in) +
    $signed(phase_s_power_in) + $signed(phase_t_power_in);
  wire [2:0]           ph  = ~{phase_t_power_in[PW-1],
    phase_s_power_in[PW-1], phase_r_power_in[PW-1]};
  reg  [31:0]          hi_q;
  reg                  last_q;
  // High time of the current pulse, and which drive pulsed last
  always @(posedge core_clk_in) begin
    hi_q <= (m1 | m2) ? hi_q + 32'h1 : 32'h0;
    if (!resetn_in)
      last_q <= 1'b1;
    else if (m1 | m2)
      last_q <= m2;
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  a_drive_exclusive: assert property (!(m1 && m2))
    else $error("both drives high");
  a_integ_follow: assert property (integrate_enable_out == !nl)
    else $error("integrate enable wrong");
  a_noload_quiet: assert property (nl [*2] |-> !m1 && !m2)
    else $error("drive high in no-load");
  a_periph_quiet: assert property (
    !operating_mode_select_in[1] [*2] |-> !m1 && !m2)
    else $error("drive high outside standalone");
  a_sign_abs: assert property (acc == 2'h1 || acc == 2'h2
    |=> total_sign_out) else $error("sign low in abs mode");
  a_sign_total: assert property ($past(resetn_in) &&
    $past(acc[0] == acc[1]) |-> total_sign_out == !$past(sum[PW+1]))
    else $error("total sign wrong");
  a_sign_phase: assert property ($past(resetn_in)
    |-> phase_sign_out == $past(ph)) else $error("phase sign wrong");
  a_width_exact: assert property ($fell(m1 | m2) &&
    $past(operating_mode_select_in[1] && !nl) |->
    hi_q == (energy_type_select_in ? LONG_CYC : SHORT_CYC))
    else $error("pulse width wrong");
  a_drive_alternate: assert property ($rose(m1 | m2) |-> m1 == last_q)
    else $error("drives not alternating");
  a_led_noload: assert property (nl |=> !led_pulse_out)
    else $error("LED pulse in no-load");
endmodule // epsd_drive_sva

bind epsd_energy_pulse_stepper_drive epsd_drive_sva #(.PW(PW),
  .SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) epsd_drive_sva_i (.*);

// >>> tb/epsd_motor_model.sv
// Stepper counter model: counts steps, flags a coil stepping twice.
// Assumes the drive signals are sampled on the core clock.
`timescale 1ns/1ns
module epsd_motor_model (
  input  wire        core_clk_in,
  input  wire        resetn_in,
  input  wire        coil_a_in,
  input  wire        coil_b_in,
  output reg  [15:0] step_count_out,
  output reg         order_fault_out
);
  reg a_q, b_q, last_b_q;
  always @(posedge core_clk_in) begin
    a_q <= coil_a_in;
    b_q <= coil_b_in;
    if (!resetn_in) begin
      step_count_out  <= 16'h0;
      order_fault_out <= 1'h0;
      last_b_q        <= 1'h1;
    end else if ((coil_a_in & !a_q) | (coil_b_in & !b_q)) begin
      step_count_out <= step_count_out + 16'h1;
      last_b_q       <= coil_b_in;
      if (coil_b_in == last_b_q)
        order_fault_out <= 1'h1;
    end
  end
endmodule // epsd_motor_model

// >>> tb/epsd_energy_pulse_stepper_drive_tb_top.sv
// Testbench: drives energy pulses and modes, counts steps and LED pulses.
// Assumes the design, checker and motor model are compiled first.
`timescale 1ns/1ns
module epsd_energy_pulse_stepper_drive_tb_top;
  reg         clk = 1'h0, rstn = 1'h0, nl = 1'h0, ep = 1'h0, ty = 1'h0;
  reg  [1:0]  op = 2'h0, rate = 2'h0, acc = 2'h0;
  reg  [23:0] pr = 24'h10, ps = 24'h10, pt = 24'h10;
  wire        ie, ts, m1, m2, led, fault;
  wire [2:0]  psn;
  wire [15:0] steps;
  integer     fail_count = 0, checked = 0, led_cnt = 0, cyc = 0, s0, i;
  integer     dv [0:3] = '{64, 128, 32, 256};
  epsd_energy_pulse_stepper_drive #(.SHORT_CYC(10), .LONG_CYC(50))
    epsd_energy_pulse_stepper_drive_i (.core_clk_in(clk),
    .resetn_in(rstn), .operating_mode_select_in(op),
    .energy_type_select_in(ty), .motor_rate_select_in(rate),
    .negative_accumulation_mode_in(acc), .no_load_flag_in(nl),
    .phase_r_power_in(pr), .phase_s_power_in(ps), .phase_t_power_in(pt),
    .energy_pulse_in(ep), .integrate_enable_out(ie), .total_sign_out(ts),
    .phase_sign_out(psn), .motor_drive_first_out(m1),
    .motor_drive_second_out(m2), .led_pulse_out(led));
  epsd_motor_model epsd_motor_model_i (.core_clk_in(clk), .resetn_in(rstn),
    .coil_a_in(m1), .coil_b_in(m2), .step_count_out(steps),
    .order_fault_out(fault));
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (led === 1'h1)
      led_cnt <= led_cnt + 1;
    if (cyc == 20000) begin
      $display("ERROR %0t: timeout", $time);
      fail_count = fail_count + 1;
      tally_and_finish;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("ERROR %0t: got %0d expected %0d", $time, got, exp);
      end
    end
  endtask
  // Leaving standalone for two cycles clears the dividers
  task burst(input [1:0] o, input t, input [1:0] r, a, input [15:0] n);
    begin
      @(posedge clk);
      #1 op = 2'h0;
      repeat (2) @(posedge clk);
      #1 {op, ty, rate, acc} = {o, t, r, a};
      led_cnt = 0;
      s0 = steps;
      ep = 1'h1;
      repeat (n) @(posedge clk);
      #1 ep = 1'h0;
      repeat (60) @(posedge clk);
      #1;
    end
  endtask
  task t_rates;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        burst(2'h3, i[2], i[1:0], 2'h1, 2 * dv[i[1:0]] * (i[2] ? 10 : 1));
        chk(steps - s0, 2);
        chk(led_cnt, i[2] ? 20 : 2);
      end
      chk(fault, 0);
      $display("t_rates done");
    end
  endtask
  task t_full;
    begin
      burst(2'h2, 1'h0, 2'h2, 2'h1, 96);
      chk(steps - s0, 3);
      chk(led_cnt, 96);
      $display("t_full done");
    end
  endtask
  task t_gate;
    begin
      nl = 1'h1;
      burst(2'h2, 1'h0, 2'h2, 2'h1, 64);
      chk(steps - s0, 0);
      chk(ie, 0);
      chk(led_cnt, 0);
      nl = 1'h0;
      burst(2'h1, 1'h0, 2'h2, 2'h1, 64);
      chk(steps - s0, 0);
      chk(ie, 1);
      $display("t_gate done");
    end
  endtask
  task t_neg;
    begin
      pr = 24'hfffff0;
      ps = 24'h1;
      pt = 24'h1;
      for (i = 0; i < 4; i = i + 1) begin
        burst(2'h2, 1'h0, 2'h2, i[1:0], 32);
        chk(steps - s0, i != 0);
        chk(ts, i == 1 || i == 2);
        chk(psn, 3'h6);
      end
      $display("t_neg done");
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1 rstn = 1'h1;
    t_rates;
    t_full;
    t_gate;
    t_neg;
    tally_and_finish;
  end
endmodule // epsd_energy_pulse_stepper_drive_tb_top
